/* File: rtl/adsr_pkg.sv */
// Purpose: shared constants, types and helpers of the converter serial retrieval block
// Assumes: host link is clock idle low, launch on rising, sample on falling edge
// Notes: the config word layout doubles as the packed struct bit order
//
// How it works
// - mode bit 0 keeps conversions running back to back, chip select regardless.
// - mode bit 1 starts a conversion only on a written single-shot bit.
// - latest result stays buffered unchanged until a newer result replaces it.
// - result leaves msb first, bit 15 at the first rising serial edge.
// - incoming config bits are sampled on every falling serial edge.
// - transfer is 32 bits with readback, or 16 bits ended by chip select.
// - 32-bit transfer sends result two bytes then config readback two bytes.
// - readback half returns the config written in the same transfer if it qualified, else the held config.
// - chip select high resets all serial logic including the bit counters.
// - after chip select falls the buffered result goes out from the first edge.
// - ready line low at start only for a fresh result, else old one resent.
// - exactly two registers: conversion result and configuration.
// - result register is read only, twos complement, zero until first conversion.
// - config resets to 058Bh with the documented field placement.
// - single-shot bit starts a conversion only when powered down and idle.
// - single-shot bit always reads back as zero.
// - input select maps to the documented positive and negative input pairs.
// - config word accepted only when its write-qualify code equals 01.
// - data change on rising serial edges and are sampled on falling ones.
// - reserved bit 0 ignores writes and reads back as one.

package adsr_pkg;

    typedef logic [15:0] adsr_word_t;

    // config word, bit 15 down to bit 0
    typedef struct packed {
        logic ss;
        logic [2:0] input_select;
        logic [2:0] gain_range_select;
        logic mode;
        logic [2:0] sample_rate_select;
        logic temp_sensor_select;
        logic output_weak_pull_enable;
        logic [1:0] write_qualify_code;
        logic rsvd;
    } adsr_cfg_s;

    // analog input pair chosen by the input select field
    typedef struct packed {
        logic [1:0] positive_input_sel;
        logic [2:0] negative_input_sel;
    } adsr_pair_s;

    typedef enum logic {CV_IDLE, CV_BUSY} adsr_conv_e;

    // field positions
    localparam int SS_POS = 15;
    localparam int MUX_POS = 12;
    localparam int GAIN_POS = 9;
    localparam int MODE_POS = 8;
    localparam int RATE_POS = 5;
    localparam int TEMP_POS = 4;
    localparam int PULL_POS = 3;
    localparam int WQ_POS = 1;
    localparam int RSVD_POS = 0;

    // reset values
    localparam adsr_word_t CFG_RESET = 16'h058B;
    localparam adsr_word_t RESULT_RESET = 16'h0000;

    // codes
    localparam logic [1:0] WQ_VALID = 2'h1;
    localparam logic MODE_CONT = 1'h0;
    localparam logic MODE_SINGLE = 1'h1;
    localparam logic [2:0] NEG_GROUND = 3'h4;
    localparam logic [2:0] NEG_ANALOG_INPUT_THREE = 3'h3;

    // bit counts of a transfer
    localparam logic [4:0] HALF_LAST = 5'h0F;
    localparam int XFER_SHORT = 16;
    localparam int XFER_LONG = 32;

    // clean a received word into what the register holds
    function automatic adsr_word_t cfg_clean(input adsr_word_t w);
        adsr_word_t v;
        v = w;
        v[SS_POS] = 1'b0;
        v[RSVD_POS] = 1'b1;
        return v;
    endfunction

    function automatic logic cfg_qualified(input adsr_word_t w);
        return w[WQ_POS +: 2] == WQ_VALID;
    endfunction

    function automatic adsr_pair_s mux_decode(input logic [2:0] sel);
        adsr_pair_s p;
        p = '0;
        case (sel)
            3'h0: begin
                p.positive_input_sel = 2'h0;
                p.negative_input_sel = 3'h1;
            end
            3'h1: begin
                p.positive_input_sel = 2'h0;
                p.negative_input_sel = NEG_ANALOG_INPUT_THREE;
            end
            3'h2: begin
                p.positive_input_sel = 2'h1;
                p.negative_input_sel = NEG_ANALOG_INPUT_THREE;
            end
            3'h3: begin
                p.positive_input_sel = 2'h2;
                p.negative_input_sel = NEG_ANALOG_INPUT_THREE;
            end
            default: begin
                p.positive_input_sel = sel[1:0];
                p.negative_input_sel = NEG_GROUND;
            end
        endcase
        return p;
    endfunction

endpackage

/* File: rtl/adsr_sync.sv */
// Purpose: two flip-flop level synchroniser into the system clock
// Assumes: input is a slow level from another clock or a pin
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps

module adsr_sync (
    // system side
    input wire logic clock,
    input wire logic nrst,
    // level in and out
    input wire logic d,
    output logic q,
    input wire logic reset_val
);
    logic meta_r;
    logic meta_nxt;
    logic q_nxt;
    logic hold_r;

    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    // reset value is a tie-off constant at the instance
    always_ff @(posedge clock) begin
        if (!nrst) begin
            // both stages start at the pin's idle level so no false edge follows reset
            meta_r <= reset_val;
            hold_r <= reset_val;
        end else begin
            meta_r <= meta_nxt;
            hold_r <= q_nxt;
        end
    end

    assign q = hold_r;
endmodule

/* File: rtl/adsr_top.sv */
// Purpose: serial retrieval and register block of a 16-bit converter
// Assumes: host leaves 3 system clocks between chip select fall and first rising edge
// Assumes: chip select stays low 4 system clocks after the 16th falling edge, else the word is lost
// Notes: serial logic runs on sclk and is cleared by chip select high
`timescale 1ns/1ps

module adsr_top (
    // system clock and reset
    input wire logic clock,
    input wire logic nrst,
    // serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout_o,
    output logic dout_oe,
    output logic dout_pull_en,
    // analog front end
    output logic conv_start,
    output logic conv_busy,
    input wire logic conv_done,
    input wire adsr_pkg::adsr_word_t conv_data,
    output adsr_pkg::adsr_cfg_s cfg_out,
    output adsr_pkg::adsr_pair_s input_pair
);
    import adsr_pkg::*;

    // ------------------------------------------------------------
    // cross-domain signals
    // ------------------------------------------------------------
    logic cs_idle;
    logic rx_seen;
    logic rx_seen_d_r;
    logic rx_seen_d_nxt;
    logic cs_idle_d_r;
    logic cs_idle_d_nxt;

    // ------------------------------------------------------------
    // system domain state
    // ------------------------------------------------------------
    adsr_cfg_s cfg_r;
    adsr_cfg_s cfg_nxt;
    adsr_word_t result_r;
    adsr_word_t result_nxt;
    logic fresh_r;
    logic fresh_nxt;
    adsr_word_t tx_word_r;
    adsr_word_t tx_word_nxt;
    logic lock_fresh_r;
    logic lock_fresh_nxt;
    adsr_conv_e state_r;
    adsr_conv_e state_nxt;
    logic start_r;
    logic start_nxt;
    adsr_pair_s pair_r;
    adsr_pair_s pair_nxt;

    // ------------------------------------------------------------
    // link domain state
    // ------------------------------------------------------------
    logic [4:0] tx_cnt_r;
    logic [4:0] tx_cnt_nxt;
    logic started_r;
    logic started_nxt;
    logic shift_r;
    logic shift_nxt;
    logic [4:0] rx_cnt_r;
    logic [4:0] rx_cnt_nxt;
    adsr_word_t rx_sh_r;
    adsr_word_t rx_sh_nxt;
    adsr_word_t rx_hold_r;
    adsr_word_t rx_hold_nxt;
    logic rx_flag_r;
    logic rx_flag_nxt;
    adsr_word_t readback;

    logic apply;
    adsr_cfg_s new_cfg;
    logic xfer_begin;

    // ------------------------------------------------------------
    // synchronisers into the system clock
    // ------------------------------------------------------------
    adsr_sync u_cs_sync (
        .clock(clock),
        .nrst(nrst),
        .d(cs_n),
        .q(cs_idle),
        .reset_val(1'b1)
    );

    adsr_sync u_rx_sync (
        .clock(clock),
        .nrst(nrst),
        .d(rx_flag_r),
        .q(rx_seen),
        .reset_val(1'b0)
    );

    always_comb begin
        rx_seen_d_nxt = rx_seen;
        cs_idle_d_nxt = cs_idle;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rx_seen_d_r <= 1'b0;
            cs_idle_d_r <= 1'b1;
        end else begin
            rx_seen_d_r <= rx_seen_d_nxt;
            cs_idle_d_r <= cs_idle_d_nxt;
        end
    end

    // a full 16-bit word has arrived; hold register is stable while the flag stays up
    assign apply = rx_seen & ~rx_seen_d_r & cfg_qualified(rx_hold_r);
    assign new_cfg = adsr_cfg_s'(cfg_clean(rx_hold_r));
    assign xfer_begin = cs_idle_d_r & ~cs_idle;

    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------
    // the pair decode is registered with the word so both move on one edge
    always_comb begin
        cfg_nxt = cfg_r;
        if (apply) begin
            cfg_nxt = new_cfg;
        end
        pair_nxt = mux_decode(cfg_nxt.input_select);
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cfg_r <= adsr_cfg_s'(CFG_RESET);
            pair_r <= mux_decode(CFG_RESET[MUX_POS +: 3]);
        end else begin
            cfg_r <= cfg_nxt;
            pair_r <= pair_nxt;
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        start_nxt = 1'b0;
        case (state_r)
            CV_IDLE: begin
                if (cfg_nxt.mode == MODE_CONT) begin
                    start_nxt = 1'b1;
                    state_nxt = CV_BUSY;
                end else if (apply && rx_hold_r[SS_POS]) begin
                    start_nxt = 1'b1;
                    state_nxt = CV_BUSY;
                end
            end
            CV_BUSY: begin
                // a start request while busy is dropped
                if (conv_done) begin
                    if (cfg_nxt.mode == MODE_CONT) begin
                        start_nxt = 1'b1;
                    end else begin
                        state_nxt = CV_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = CV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_r <= CV_IDLE;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            start_r <= start_nxt;
        end
    end

    // ------------------------------------------------------------
    // result buffer and ready level
    // ------------------------------------------------------------
    always_comb begin
        result_nxt = result_r;
        fresh_nxt = fresh_r;
        // ready indication is consumed once a transfer starts
        if (xfer_begin) begin
            fresh_nxt = 1'b0;
        end
        // a result landing in the same cycle wins over the clear
        if (state_r == CV_BUSY && conv_done) begin
            result_nxt = conv_data;
            fresh_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            result_r <= RESULT_RESET;
            fresh_r <= 1'b0;
        end else begin
            result_r <= result_nxt;
            fresh_r <= fresh_nxt;
        end
    end

    // ------------------------------------------------------------
    // transfer snapshot
    // ------------------------------------------------------------
    // word and ready level freeze while chip select is low, so the link reads steady flops
    always_comb begin
        tx_word_nxt = tx_word_r;
        lock_fresh_nxt = lock_fresh_r;
        if (cs_idle) begin
            tx_word_nxt = result_r;
            lock_fresh_nxt = fresh_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            tx_word_r <= RESULT_RESET;
            lock_fresh_r <= 1'b0;
        end else begin
            tx_word_r <= tx_word_nxt;
            lock_fresh_r <= lock_fresh_nxt;
        end
    end

    // ------------------------------------------------------------
    // link transmit side, rising serial edges
    // ------------------------------------------------------------
    // second half echoes the word just written when it qualified, else the held config
    always_comb begin
        if (cfg_qualified(rx_hold_r)) begin
            readback = cfg_clean(rx_hold_r);
        end else begin
            readback = adsr_word_t'(cfg_r);
        end
    end

    always_comb begin
        tx_cnt_nxt = tx_cnt_r + 5'h01;
        started_nxt = 1'b1;
        if (tx_cnt_r <= HALF_LAST) begin
            shift_nxt = tx_word_r[4'hF - tx_cnt_r[3:0]];
        end else begin
            shift_nxt = readback[4'hF - tx_cnt_r[3:0]];
        end
    end

    // chip select high clears the link logic without needing a serial edge
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            tx_cnt_r <= 5'h00;
            started_r <= 1'b0;
            shift_r <= 1'b0;
        end else begin
            tx_cnt_r <= tx_cnt_nxt;
            started_r <= started_nxt;
            shift_r <= shift_nxt;
        end
    end

    // ------------------------------------------------------------
    // link receive side, falling serial edges
    // ------------------------------------------------------------
    always_comb begin
        rx_cnt_nxt = rx_cnt_r + 5'h01;
        rx_sh_nxt = {rx_sh_r[14:0], din};
        rx_hold_nxt = rx_hold_r;
        rx_flag_nxt = rx_flag_r;
        if (rx_cnt_r == HALF_LAST && !rx_flag_r) begin
            rx_hold_nxt = rx_sh_nxt;
            rx_flag_nxt = 1'b1;
        end
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rx_cnt_r <= 5'h00;
            rx_sh_r <= 16'h0000;
            rx_hold_r <= 16'h0000;
            rx_flag_r <= 1'b0;
        end else begin
            rx_cnt_r <= rx_cnt_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_hold_r <= rx_hold_nxt;
            rx_flag_r <= rx_flag_nxt;
        end
    end

    // ------------------------------------------------------------
    // pins and front end
    // ------------------------------------------------------------
    // before the first rising edge the line shows the ready level
    assign dout_o = started_r ? shift_r : ~lock_fresh_r;
    assign dout_oe = ~cs_n;
    assign dout_pull_en = cs_n & cfg_r.output_weak_pull_enable;
    assign conv_start = start_r;
    assign conv_busy = (state_r == CV_BUSY);
    assign cfg_out = cfg_r;
    assign input_pair = pair_r;

endmodule

/* File: sim/adsr_checker.sv */
// Purpose: concurrent checks on the ports of adsr_top
// Assumes: every checked relation lives in the system clock domain
// Notes: serial bit order is judged by the bench, which sees both ends
`timescale 1ns/1ps

module adsr_checker
    import adsr_pkg::*;
(
    // system
    input wire logic clock,
    input wire logic nrst,
    // serial pins
    input wire logic cs_n,
    input wire logic dout_oe,
    input wire logic dout_pull_en,
    // front end
    input wire logic conv_start,
    input wire logic conv_busy,
    input wire logic conv_done,
    input wire adsr_pkg::adsr_cfg_s cfg_out,
    input wire adsr_pkg::adsr_pair_s input_pair
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_reset_values: assert property (disable iff (1'b0)
        !nrst |=> cfg_out == CFG_RESET && !conv_busy && !conv_start)
        else $error("config or front end not at reset value");
    a_oe_follows_cs: assert property (dout_oe == !cs_n)
        else $error("output enable does not follow chip select");
    // guard: the pull may come through a synchroniser, chip select edges are far apart
    a_pull_when_idle: assert property (cs_n == $past(cs_n, 4) && $stable(cfg_out) |->
        dout_pull_en == (cs_n && cfg_out.output_weak_pull_enable))
        else $error("pull enable wrong");
    a_ss_reads_zero: assert property (!cfg_out.ss)
        else $error("single-shot bit reads one");
    a_rsvd_reads_one: assert property (cfg_out.rsvd)
        else $error("reserved bit reads zero");
    a_mux_ground: assert property (cfg_out.input_select[2] |->
        input_pair == {cfg_out.input_select[1:0], NEG_GROUND})
        else $error("single ended input pair wrong");
    a_start_then_busy: assert property (conv_start |=> conv_busy)
        else $error("start not followed by busy");
    // the mode that counts is the one in force after the done edge
    a_cont_restart: assert property (
        conv_busy && conv_done ##1 cfg_out.mode == MODE_CONT |-> conv_start)
        else $error("continuous mode did not restart");
    a_no_start_busy: assert property (conv_busy && !conv_done |=> !conv_start)
        else $error("start while a conversion runs");
    cover property (conv_start && cfg_out.mode == MODE_CONT);
    cover property ($fell(cs_n));
    cover property ($changed(cfg_out));
endmodule

bind adsr_top adsr_checker i_chk (.clock, .nrst, .cs_n, .dout_oe, .dout_pull_en,
    .conv_start, .conv_busy, .conv_done, .cfg_out, .input_pair);

/* File: sim/adsr_host_model.sv */
// Purpose: host serial master model facing the converter block
// Assumes: clock idle low, change on rising, sample on falling edge
// Notes: data in is inverted once released so a stale bit is never seen
`timescale 1ns/1ps

module adsr_host_model (
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout_o
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // odd start offset keeps every link edge away from system clock edges
    task automatic xfer(input logic [15:0] w, input int n, output logic [31:0] r,
            output logic rdy);
        #1.3 cs_n = 1'b0;
        #40 rdy = dout_o;
        r = '0;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b1;
            din = w[15 - i % 16];
            #80 sclk = 1'b0;
            r = {r[30:0], dout_o};
            #80;
        end
        #40 cs_n = 1'b1;
        din = ~din;
        #40;
    endtask
endmodule

/* File: sim/tb_adsr_top.sv */
// Purpose: self-checking bench of the converter serial retrieval block
// Assumes: front end answers each start after a random delay
// Notes: conversions are long so later writes land while one runs
`timescale 1ns/1ps

module tb_adsr_top;
    import adsr_pkg::*;
    logic clock, nrst, conv_done, dout_o, dout_oe, dout_pull_en, conv_start, conv_busy;
    logic sclk, cs_n, din, rdy;
    logic [31:0] r;
    adsr_word_t conv_data, exp_res, w;
    adsr_cfg_s cfg_out;
    adsr_pair_s input_pair;
    int mismatches = 0, comparisons = 0, starts = 0, cnt = 0, s;
    wire dout_pin = dout_oe ? dout_o : (dout_pull_en ? 1'b1 : 1'bz);

    adsr_top i_dut (.clock, .nrst, .sclk, .cs_n, .din, .dout_o, .dout_oe, .dout_pull_en,
        .conv_start, .conv_busy, .conv_done, .conv_data, .cfg_out, .input_pair);
    adsr_host_model i_host (.sclk, .cs_n, .din, .dout_o(dout_pin));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // ----------------------------------------
    // front end model
    // ----------------------------------------
    always @(posedge clock) begin
        conv_done <= 1'b0;
        if (cnt > 0) cnt <= cnt - 1;
        if (cnt == 1) begin
            conv_done <= 1'b1;
            conv_data <= adsr_word_t'($urandom);
            exp_res <= conv_data;
        end
        if (conv_done) exp_res <= conv_data;
        if (conv_start) begin
            starts <= starts + 1;
            cnt <= 3500 + $urandom_range(500);
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic adsr_word_t exp_cfg(input adsr_word_t v);
        return {1'b0, v[14:1], 1'b1};
    endfunction
    function automatic adsr_pair_s exp_pair(input logic [2:0] v);
        if (v[2]) return {v[1:0], 3'h4};
        return (v == 3'h0) ? 5'h01 : {v[1:0] - 2'h1, 3'h3};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic xf(input adsr_word_t wd, input int n);
        i_host.xfer(wd, n, r, rdy);
        @(posedge clock);
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 5000 && conv_busy !== 1'b0; k++) @(posedge clock);
        repeat (4) @(posedge clock);
        check(conv_busy, 0, "conversion never ended");
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        conv_done = 1'b0;
        conv_data = '0;
        exp_res = '0;
        void'($urandom(32'h5A72BA53));
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        check(cfg_out, CFG_RESET, "config reset");
        xf(16'h0000, 32);
        check(r, {RESULT_RESET, CFG_RESET}, "first frame");
        check(rdy, 1, "stale ready");
        for (int i = 0; i < 8; i++) begin
            w = adsr_word_t'($urandom);
            w[14:12] = i[2:0];
            w[8] = MODE_SINGLE;
            w[15] = 1'b1;
            w[2:1] = WQ_VALID;
            s = starts;
            xf(w, 32);
            check(r[15:0], exp_cfg(w), "readback");
            xf(w ^ ((i % 3 == 0) ? 16'h0002 : (i % 3 == 1) ? 16'h0006 : 16'h0004), 32);
            check(r[15:0], exp_cfg(w), "unqualified word");
            xf(w, 16);
            wait_idle();
            check(starts - s, 1, "single starts");
            check(cfg_out, exp_cfg(w), "config");
            check(input_pair, exp_pair(i[2:0]), "input pair");
            check(dout_pull_en, w[3], "pull");
            xf(16'h0000, 16);
            check({rdy, r[15:0]}, {1'b0, exp_res}, "fresh result");
            xf(16'hFFFF, 16);
            check({rdy, r[15:0]}, {1'b1, exp_res}, "resent result");
        end
        s = starts;
        xf(16'h048B, 32);
        check(r[15:0], 16'h048B, "continuous readback");
        repeat (13000) @(posedge clock);
        check(starts - s >= 3, 1, "continuous starts");
        xf(CFG_RESET, 32);
        wait_idle();
        s = starts;
        repeat (4500) @(posedge clock);
        check(starts, s, "start in single mode");
        print_verdict();
    end
    initial begin
        repeat (90000) @(posedge clock);
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        print_verdict();
    end
endmodule
